// *** hdl/rsd_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef RSD_MAP_SVH
`define RSD_MAP_SVH
// clause 22 direct register indices
`define RSD_REG_CH_STATUS     5'h05
`define RSD_REG_CH_CTRL      5'h04
`define RSD_REG_ARS_CTRL     5'h0A
`define RSD_REG_IND_ADDR     5'h1E
`define RSD_REG_IND_DATA     5'h1F
// extended space base
`define RSD_EXT_BASE         16'h8000
`define RSD_EXT_REGS         4
// field positions, register 10
`define RSD_B_RX_FREE        15
`define RSD_B_ARS_EN_HI      13
`define RSD_B_ARS_EN_LO      12
`define RSD_B_HOLD           11
`define RSD_B_OVR            10
// register 4 and 5
`define RSD_B_FIFO_RECENTER  2
`define RSD_B_LOCK           10
// reset values
`define RSD_ARS_CTRL_RST     16'h0800
`define RSD_PATTERN_RST      10'h17C
// management clock divider (hclk cycles per mdc half period)
`define RSD_MDC_HALF         8'h08
// amount of transfers in a clause 22 frame
`define RSD_FRAME_BITS       7'h40
`endif

// *** hdl/rsd_pkg.sv ***
// types used by the device end of the management link
package rsd_pkg;
    typedef enum logic [1:0] {RSD_DP_OVERRIDE, RSD_DP_PARALLEL, RSD_DP_IDLE} rsd_dp_e;
    typedef enum logic [2:0] {
        RSD_ST_IDLE, RSD_ST_ADDR, RSD_ST_TA, RSD_ST_DATA, RSD_ST_DONE
    } rsd_frame_e;
    typedef logic [15:0] rsd_word_t;
endpackage

// *** hdl/rsd_mdio_if.sv ***
// management link between the station and the device
interface rsd_mdio_if;
    logic mdc;
    logic mdio_sta_o;
    logic mdio_sta_oe;
    logic mdio_dev_o;
    logic mdio_dev_oe;
    wire  mdio_line;
    assign mdio_line = mdio_sta_oe ? mdio_sta_o : (mdio_dev_oe ? mdio_dev_o : 1'b1);
    modport station (output mdc, output mdio_sta_o, output mdio_sta_oe, input mdio_line);
    modport device  (input mdc, output mdio_dev_o, output mdio_dev_oe, input mdio_line);
endinterface

// *** hdl/rsd_device.sv ***
// device end: management slave and rate sense datapath control
//
// Chosen here: no AHB-Lite port; the device runs from hclk and hresetn only.
`include "rsd_map.svh"

// Overview of operation
// - tx serial output always driven
// - tx rate follows rate being tried
// - override bit sends 10-bit pattern while sensing enabled
// - override clear sends parallel input data
// - hold bit matters only under override
// - hold clear: lock recenters, switches to parallel
// - hold set: wait for recenter write
// - lock resets tx and rx fifos
// - pointer collision recenters tx fifo
// - software should set hold bit
// - software avoids rx soft reset
// - rx parallel outputs always driven
// - rx clock free-run or held low
// - lock releases held rx clock immediately
// - respond when upper address matches straps
// - address lsb selects channel
// - bad writes silently dropped
// - unimplemented reads return zero
// - indirect address then data window
// - one mdio line clocked by mdc
// - lock flag triggers resets and handover
module rsd_device (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    rsd_mdio_if.device          mif,
    input  wire logic [3:0]     port_address_straps,
    input  wire logic [1:0]     rate_lock_flag,
    input  wire logic [1:0]     rate_try_strobe,
    input  wire logic [2:0]     rate_try_a,
    input  wire logic [2:0]     rate_try_b,
    input  wire logic [1:0]     tx_fifo_collide,
    input  wire logic [9:0]     tx_parallel_a,
    input  wire logic [9:0]     tx_parallel_b,
    input  wire logic [9:0]     rx_decoded_a,
    input  wire logic [9:0]     rx_decoded_b,
    input  wire logic [1:0]     rx_byte_clk_raw,
    output logic [9:0]          tx_serial_word_a,
    output logic [9:0]          tx_serial_word_b,
    output logic [2:0]          tx_rate_a,
    output logic [2:0]          tx_rate_b,
    output logic [1:0]          tx_fifo_reset,
    output logic [1:0]          rx_fifo_reset,
    output logic [9:0]          rx_parallel_a,
    output logic [9:0]          rx_parallel_b,
    output logic [1:0]          recovered_byte_clock
);
    // synchronised link inputs
    logic [1:0] mdc_s;
    logic [1:0] mdi_s;
    logic       mdc_d;
    logic       mdc_rise;
    logic       mdc_fall;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdc_s <= 2'h0;
            mdi_s <= 2'h3;
            mdc_d <= 1'b0;
        end else begin
            mdc_s <= {mdc_s[0], mif.mdc};
            mdi_s <= {mdi_s[0], mif.mdio_line};
            mdc_d <= mdc_s[1];
        end
    end
    assign mdc_rise = mdc_s[1] & ~mdc_d;
    assign mdc_fall = ~mdc_s[1] & mdc_d;

    // per channel registers
    logic [15:0] ars_ctrl_reg [2];
    logic [15:0] ind_addr_reg [2];
    logic [15:0] ext_reg      [2][`RSD_EXT_REGS];
    logic [1:0]  lock_d;
    logic [1:0]  lock_rise;
    logic [1:0]  handed_reg;
    logic [1:0]  recenter_pulse;
    assign lock_rise = rate_lock_flag & ~lock_d;

    // frame shifter
    rsd_pkg::rsd_frame_e st_reg;
    logic [6:0]  bit_cnt;
    logic [31:0] sh_reg;
    logic [15:0] rd_reg;
    logic        ones_cnt_ok;
    logic [4:0]  ones_cnt;
    logic        is_read;
    assign ones_cnt_ok = (ones_cnt == 5'h1F);

    logic [4:0] phy_reg;
    logic [4:0] reg_no;
    logic       wr_go;
    logic       wr_ch;
    logic [4:0] wr_reg;
    logic [15:0] wr_dat;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg  <= rsd_pkg::RSD_ST_IDLE;
            bit_cnt <= 7'h00;
            sh_reg  <= 32'h0000_0000;
            rd_reg  <= 16'h0000;
            ones_cnt <= 5'h00;
            is_read <= 1'b0;
            phy_reg <= 5'h00;
            reg_no  <= 5'h00;
            wr_go   <= 1'b0;
            wr_ch   <= 1'b0;
            wr_reg  <= 5'h00;
            wr_dat  <= 16'h0000;
            mif.mdio_dev_o  <= 1'b1;
            mif.mdio_dev_oe <= 1'b0;
        end else begin
            wr_go <= 1'b0;
            if (mdc_rise) begin
                sh_reg <= {sh_reg[30:0], mdi_s[1]};
                case (st_reg)
                    rsd_pkg::RSD_ST_IDLE: begin
                        ones_cnt <= mdi_s[1] ? (ones_cnt_ok ? ones_cnt : ones_cnt + 5'h01) : 5'h00;
                        if (ones_cnt_ok && !mdi_s[1]) begin
                            st_reg  <= rsd_pkg::RSD_ST_ADDR;
                            bit_cnt <= 7'h01;
                        end
                    end
                    rsd_pkg::RSD_ST_ADDR: begin
                        bit_cnt <= bit_cnt + 7'h01;
                        if (bit_cnt == 7'h0D) begin
                            // sh now: st2,op2,phy5,reg5 after this bit
                            is_read <= (sh_reg[10:9] == 2'b10);
                            phy_reg <= sh_reg[8:4];
                            reg_no  <= {sh_reg[3:0], mdi_s[1]};
                            st_reg  <= rsd_pkg::RSD_ST_TA;
                        end
                    end
                    rsd_pkg::RSD_ST_TA: begin
                        bit_cnt <= bit_cnt + 7'h01;
                        if (bit_cnt == 7'h0F) begin
                            st_reg <= rsd_pkg::RSD_ST_DATA;
                        end
                    end
                    rsd_pkg::RSD_ST_DATA: begin
                        bit_cnt <= bit_cnt + 7'h01;
                        if (bit_cnt == 7'h1F) begin
                            st_reg <= rsd_pkg::RSD_ST_DONE;
                            if (!is_read && phy_reg[4:1] == port_address_straps) begin
                                wr_go  <= 1'b1;
                                wr_ch  <= phy_reg[0];
                                wr_reg <= reg_no;
                                wr_dat <= {sh_reg[14:0], mdi_s[1]};
                            end
                        end
                    end
                    default: begin
                        st_reg   <= rsd_pkg::RSD_ST_IDLE;
                        ones_cnt <= 5'h00;
                    end
                endcase
            end
            // read drive: turnaround second bit low, then data msb first
            if (mdc_fall && is_read && phy_reg[4:1] == port_address_straps) begin
                if (st_reg == rsd_pkg::RSD_ST_TA && bit_cnt == 7'h0F) begin
                    mif.mdio_dev_oe <= 1'b1;
                    mif.mdio_dev_o  <= 1'b0;
                    rd_reg <= rd_lookup(phy_reg[0], reg_no);
                end else if (st_reg == rsd_pkg::RSD_ST_DATA) begin
                    mif.mdio_dev_o <= rd_reg[15];
                    rd_reg <= {rd_reg[14:0], 1'b0};
                end else begin
                    mif.mdio_dev_oe <= 1'b0;
                end
            end else if (mdc_fall && st_reg != rsd_pkg::RSD_ST_DATA) begin
                mif.mdio_dev_oe <= 1'b0;
            end
        end
    end

    function automatic logic [15:0] rd_lookup(input logic c, input logic [4:0] r);
        logic [15:0] v;
        logic [15:0] a;
        v = 16'h0000;
        a = ind_addr_reg[c];
        if (r == `RSD_REG_ARS_CTRL) begin
            v = ars_ctrl_reg[c];
        end else if (r == `RSD_REG_CH_STATUS) begin
            v = {5'h00, rate_lock_flag[c], 10'h000};
        end else if (r == `RSD_REG_IND_ADDR) begin
            v = a;
        end else if (r == `RSD_REG_IND_DATA) begin
            if (a[15:2] == `RSD_EXT_BASE >> 2) begin
                v = ext_reg[c][a[1:0]];
            end
        end
        return v;
    endfunction

    // register writes; others silently dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int c = 0; c < 2; c++) begin
                ars_ctrl_reg[c] <= `RSD_ARS_CTRL_RST | 16'(`RSD_PATTERN_RST);
                ind_addr_reg[c] <= 16'h0000;
                for (int e = 0; e < `RSD_EXT_REGS; e++) begin
                    ext_reg[c][e] <= 16'h0000;
                end
            end
            recenter_pulse <= 2'h0;
        end else begin
            recenter_pulse <= 2'h0;
            if (wr_go) begin
                if (wr_reg == `RSD_REG_ARS_CTRL) begin
                    ars_ctrl_reg[wr_ch] <= wr_dat;
                end else if (wr_reg == `RSD_REG_CH_CTRL) begin
                    recenter_pulse[wr_ch] <= wr_dat[`RSD_B_FIFO_RECENTER];
                end else if (wr_reg == `RSD_REG_IND_ADDR) begin
                    ind_addr_reg[wr_ch] <= wr_dat;
                end else if (wr_reg == `RSD_REG_IND_DATA) begin
                    if (ind_addr_reg[wr_ch][15:2] == `RSD_EXT_BASE >> 2) begin
                        ext_reg[wr_ch][ind_addr_reg[wr_ch][1:0]] <= wr_dat;
                    end
                end
            end
        end
    end

    // datapath control per channel
    logic [9:0] tx_o   [2];
    logic [9:0] rx_o   [2];
    logic [2:0] rate_o [2];
    assign tx_serial_word_a = tx_o[0];
    assign tx_serial_word_b = tx_o[1];
    assign rx_parallel_a = rx_o[0];
    assign rx_parallel_b = rx_o[1];
    assign tx_rate_a = rate_o[0];
    assign tx_rate_b = rate_o[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_d <= 2'h0;
            handed_reg <= 2'h0;
            tx_fifo_reset <= 2'h0;
            rx_fifo_reset <= 2'h0;
            recovered_byte_clock <= 2'h0;
            for (int c = 0; c < 2; c++) begin
                tx_o[c] <= 10'h000;
                rx_o[c] <= 10'h000;
                rate_o[c] <= 3'h0;
            end
        end else begin
            lock_d <= rate_lock_flag;
            for (int c = 0; c < 2; c++) begin
                logic ars_on;
                logic ovr;
                logic hold;
                ars_on = |ars_ctrl_reg[c][`RSD_B_ARS_EN_HI:`RSD_B_ARS_EN_LO];
                ovr  = ars_on & ars_ctrl_reg[c][`RSD_B_OVR];
                hold = ovr & ars_ctrl_reg[c][`RSD_B_HOLD];
                if (rate_try_strobe[c]) begin
                    rate_o[c] <= (c == 0) ? rate_try_a : rate_try_b;
                end
                // tx fifo resets on lock, collision or recenter write; rx fifo on lock only
                tx_fifo_reset[c] <= lock_rise[c] | tx_fifo_collide[c]
                                    | recenter_pulse[c];
                rx_fifo_reset[c] <= lock_rise[c];
                if (!rate_lock_flag[c]) begin
                    handed_reg[c] <= 1'b0;
                end else if (lock_rise[c] && !hold) begin
                    handed_reg[c] <= 1'b1;
                end else if (recenter_pulse[c]) begin
                    handed_reg[c] <= 1'b1;
                end
                // always drive a serial word
                if (ovr && !handed_reg[c]) begin
                    tx_o[c] <= ars_ctrl_reg[c][9:0];
                end else begin
                    tx_o[c] <= (c == 0) ? tx_parallel_a : tx_parallel_b;
                end
                rx_o[c] <= (c == 0) ? rx_decoded_a : rx_decoded_b;
                if (ars_on && !ars_ctrl_reg[c][`RSD_B_RX_FREE] && !rate_lock_flag[c]) begin
                    recovered_byte_clock[c] <= 1'b0;
                end else begin
                    recovered_byte_clock[c] <= rx_byte_clk_raw[c];
                end
            end
        end
    end
endmodule

// *** hdl/rsd_station.sv ***
// station end: ahb-lite command registers driving clause 22 frames
`include "rsd_map.svh"
module rsd_station (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    rsd_mdio_if.station        mif
);
    // 0x0 command: [31] go,[28] read,[25:21] phy,[20:16] reg,[15:0] data
    // 0x4 status: [16] busy,[15:0] read data
    logic        ph_wr;
    logic        ph_rd;
    logic [3:0]  ph_addr;
    logic [31:0] cmd_reg;
    logic        busy_reg;
    logic [15:0] rdat_reg;
    logic [7:0]  div_cnt;
    logic [6:0]  bit_cnt;
    logic [63:0] sh_reg;
    logic        go_pulse;

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr   <= 1'b0;
            ph_rd   <= 1'b0;
            ph_addr <= 4'h0;
        end else if (hready) begin
            ph_wr   <= hsel & htrans[1] & hwrite;
            ph_rd   <= hsel & htrans[1] & ~hwrite;
            ph_addr <= haddr[3:0];
        end
    end

    // data phase: zero wait states, okay always
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_reg   <= 32'h0000_0000;
            go_pulse  <= 1'b0;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            go_pulse <= 1'b0;
            if (ph_wr && ph_addr == 4'h0 && !busy_reg) begin
                cmd_reg  <= hwdata;
                go_pulse <= hwdata[31];
            end
            if (hready && hsel && htrans[1] && !hwrite) begin
                if (haddr[3:0] == 4'h0) begin
                    hrdata <= cmd_reg;
                end else if (haddr[3:0] == 4'h4) begin
                    hrdata <= {15'h0000, busy_reg | go_pulse, rdat_reg};
                end else begin
                    hrdata <= 32'h0000_0000;
                end
            end
        end
    end

    // mdc divider and frame shifting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_reg <= 1'b0;
            rdat_reg <= 16'h0000;
            div_cnt  <= 8'h00;
            bit_cnt  <= 7'h00;
            sh_reg   <= 64'h0;
            mif.mdc  <= 1'b0;
            mif.mdio_sta_o  <= 1'b1;
            mif.mdio_sta_oe <= 1'b0;
        end else if (go_pulse) begin
            busy_reg <= 1'b1;
            bit_cnt  <= 7'h00;
            div_cnt  <= 8'h00;
            sh_reg   <= {32'hFFFF_FFFF, 2'b01, cmd_reg[28] ? 2'b10 : 2'b01,
                         cmd_reg[25:21], cmd_reg[20:16],
                         cmd_reg[28] ? 2'b11 : 2'b10, cmd_reg[15:0]};
        end else if (busy_reg) begin
            div_cnt <= div_cnt + 8'h01;
            if (div_cnt == `RSD_MDC_HALF - 8'h01) begin
                div_cnt <= 8'h00;
                mif.mdc <= ~mif.mdc;
                if (mif.mdc) begin
                    // falling edge: present next bit
                    if (bit_cnt == `RSD_FRAME_BITS) begin
                        busy_reg <= 1'b0;
                        mif.mdio_sta_oe <= 1'b0;
                    end else begin
                        mif.mdio_sta_o  <= sh_reg[63];
                        mif.mdio_sta_oe <= ~(cmd_reg[28] && bit_cnt >= 7'h2E);
                        sh_reg  <= {sh_reg[62:0], 1'b0};
                        bit_cnt <= bit_cnt + 7'h01;
                    end
                end else if (cmd_reg[28] && bit_cnt > 7'h30) begin
                    rdat_reg <= {rdat_reg[14:0], mif.mdio_line};
                end
            end
        end
    end
endmodule

// *** bench/rsd_monitor.sv ***
// protocol checks on the management link between station and device
module rsd_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic mdc,
    input wire logic mdio_sta_o,
    input wire logic mdio_sta_oe,
    input wire logic mdio_dev_o,
    input wire logic mdio_dev_oe,
    input wire logic mdio_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] sta_cnt_reg;
    logic [4:0] dev_cnt_reg;
    logic       mdc_d_reg;

    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // rising mdc edges counted while each end drives the line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdc_d_reg   <= 1'b0;
            sta_cnt_reg <= 7'h00;
            dev_cnt_reg <= 5'h00;
        end else begin
            mdc_d_reg   <= mdc;
            sta_cnt_reg <= !mdio_sta_oe ? 7'h00 : sta_cnt_reg + {6'h00, mdc && !mdc_d_reg};
            dev_cnt_reg <= !mdio_dev_oe ? 5'h00 : dev_cnt_reg + {4'h0, mdc && !mdc_d_reg};
        end
    end

    property p_no_contention;
        !(mdio_sta_oe && mdio_dev_oe);
    endproperty
    property p_mdc_high;
        $rose(mdc) |-> mdc[*8];
    endproperty
    property p_mdc_low;
        $fell(mdc) |-> (!mdc)[*8];
    endproperty
    property p_dev_turn;
        $rose(mdio_dev_oe) |-> !mdio_dev_o && !mdc;
    endproperty
    property p_dev_phase;
        mdio_dev_oe && $changed(mdio_dev_o) |-> !mdc;
    endproperty
    property p_sta_phase;
        mdio_sta_oe && $changed(mdio_sta_o) |-> !mdc;
    endproperty
    property p_sta_len;
        $fell(mdio_sta_oe) |-> $past(sta_cnt_reg) == 7'h2E || $past(sta_cnt_reg) == 7'h40;
    endproperty
    property p_dev_len;
        $fell(mdio_dev_oe) |-> $past(dev_cnt_reg) == 5'h11;
    endproperty

    a_no_contention: assert property (p_no_contention) else $error("both ends drive mdio");
    a_mdc_high: assert property (p_mdc_high) else $error("mdc high phase too short");
    a_mdc_low: assert property (p_mdc_low) else $error("mdc low phase too short");
    a_dev_turn: assert property (p_dev_turn) else $error("bad turnaround from device");
    a_dev_phase: assert property (p_dev_phase) else $error("device data moved with mdc high");
    a_sta_phase: assert property (p_sta_phase) else $error("station data moved with mdc high");
    a_sta_len: assert property (p_sta_len) else $error("station frame length wrong");
    a_dev_len: assert property (p_dev_len) else $error("device read data length wrong");

    // main traffic kinds seen on the link
    c_write_frame: cover property ($fell(mdio_sta_oe) && $past(sta_cnt_reg) == 7'h40);
    c_read_frame: cover property ($fell(mdio_dev_oe));
    c_turn: cover property ($rose(mdio_dev_oe) && mdio_line == 1'b0);
endmodule

// *** bench/rate_sense_datapath_mdio_control_tb.sv ***
// self-checking bench joining station and device over the management link
`include "rsd_map.svh"
module rate_sense_datapath_mdio_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] PA = 5'h14, PB = 5'h15, PX = 5'h04;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0, lock = 2'h0, strobe = 2'h0, collide = 2'h0, raw = 2'h0;
    logic [2:0]  try_a = 3'h0, try_b = 3'h0, rate_a, rate_b;
    logic [9:0]  par_a = 10'h155, par_b = 10'h0CC, dec_a = 10'h0F0, dec_b = 10'h30F;
    logic [9:0]  ser_a, ser_b, rxp_a, rxp_b;
    logic [1:0]  txr, rxr, rbc;
    logic [15:0] rd;
    int          bad_count = 0, comparisons = 0, txr_n = 0, rxr_n = 0, ra_n = 0, rb_n = 0;

    rsd_mdio_if u_rsd_mdio_if ();
    rsd_station u_rsd_station (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .mif(u_rsd_mdio_if));
    rsd_device u_rsd_device (.hclk(hclk), .hresetn(hresetn), .mif(u_rsd_mdio_if),
        .port_address_straps(4'hA), .rate_lock_flag(lock), .rate_try_strobe(strobe),
        .rate_try_a(try_a), .rate_try_b(try_b), .tx_fifo_collide(collide),
        .tx_parallel_a(par_a), .tx_parallel_b(par_b), .rx_decoded_a(dec_a),
        .rx_decoded_b(dec_b), .rx_byte_clk_raw(raw), .tx_serial_word_a(ser_a),
        .tx_serial_word_b(ser_b), .tx_rate_a(rate_a), .tx_rate_b(rate_b),
        .tx_fifo_reset(txr), .rx_fifo_reset(rxr), .rx_parallel_a(rxp_a),
        .rx_parallel_b(rxp_b), .recovered_byte_clock(rbc));
    rsd_monitor u_rsd_monitor (.hclk(hclk), .hresetn(hresetn), .mdc(u_rsd_mdio_if.mdc),
        .mdio_sta_o(u_rsd_mdio_if.mdio_sta_o), .mdio_sta_oe(u_rsd_mdio_if.mdio_sta_oe),
        .mdio_dev_o(u_rsd_mdio_if.mdio_dev_o), .mdio_dev_oe(u_rsd_mdio_if.mdio_dev_oe),
        .mdio_line(u_rsd_mdio_if.mdio_line));

    // system clock and free raw byte clock
    always #5 hclk = ~hclk;
    always #80 raw = ~raw;
    // tallies of fifo reset pulses and recovered clock edges
    always @(posedge hclk) begin
        txr_n <= txr_n + int'(txr[0]);
        rxr_n <= rxr_n + int'(rxr[0]);
    end
    always @(rbc[0]) ra_n++;
    always @(rbc[1]) rb_n++;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one single ahb-lite transfer, called just after a rising edge
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // one management frame: start it, then wait for busy to rise and fall
    task automatic mdio(input logic r, input logic [4:0] ph, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [15:0] q);
        logic [31:0] s;
        ahb(1'b1, 32'h0, {1'b1, 2'h0, r, 2'h0, ph, rg, wd}, s);
        do ahb(1'b0, 32'h4, 32'h0, s); while (s[16] !== 1'b1);
        do ahb(1'b0, 32'h4, 32'h0, s); while (s[16] !== 1'b0);
        q = s[15:0];
    endtask

    task automatic wr(input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] d);
        mdio(1'b0, ph, rg, d, rd);
        repeat (16) @(posedge hclk);
    endtask

    task automatic rdc(input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] e);
        mdio(1'b1, ph, rg, 16'h0, rd);
        chk(rd, e);
    endtask

    // addressing, channel select, discarded writes and empty reads
    task automatic t_regs();
        rdc(PA, `RSD_REG_ARS_CTRL, 16'h097C);
        wr(PB, `RSD_REG_ARS_CTRL, 16'h02A5);
        wr(PX, `RSD_REG_ARS_CTRL, 16'h0000);
        rdc(PB, `RSD_REG_ARS_CTRL, 16'h02A5);
        rdc(PA, `RSD_REG_ARS_CTRL, 16'h097C);
        rdc(PX, `RSD_REG_ARS_CTRL, 16'hFFFF);
        wr(PA, 5'h07, 16'hFFFF);
        rdc(PA, 5'h07, 16'h0000);
        wr(PA, `RSD_REG_CH_STATUS, 16'hFFFF);
        mdio(1'b1, PA, `RSD_REG_CH_STATUS, 16'h0, rd);
        chk(rd[10], 1'b0);
    endtask

    // extended space through the address pointer and data window
    task automatic t_ind();
        wr(PA, `RSD_REG_IND_ADDR, 16'h8001);
        wr(PA, `RSD_REG_IND_DATA, 16'hABCD);
        wr(PA, `RSD_REG_IND_ADDR, 16'h8002);
        wr(PA, `RSD_REG_IND_DATA, 16'h1234);
        wr(PA, `RSD_REG_IND_ADDR, 16'h8001);
        rdc(PA, `RSD_REG_IND_DATA, 16'hABCD);
        rdc(PA, `RSD_REG_IND_DATA, 16'hABCD);
        rdc(PA, `RSD_REG_IND_ADDR, 16'h8001);
    endtask

    // override pattern, rate tracking, lock handover on channel a
    task automatic t_ovr();
        int n, t, r;
        wr(PA, `RSD_REG_ARS_CTRL, 16'h36A5);
        chk(ser_a, 10'h2A5);
        try_a <= 3'h5;
        try_b <= 3'h3;
        strobe <= 2'h3;
        @(posedge hclk);
        strobe <= 2'h0;
        repeat (2) @(posedge hclk);
        chk(rate_a, 3'h5);
        chk(rate_b, 3'h3);
        n = ra_n;
        t = txr_n;
        r = rxr_n;
        repeat (32) @(posedge hclk);
        chk(16'(ra_n - n), 16'h0);
        lock <= 2'h1;
        repeat (20) @(posedge hclk);
        chk(16'(txr_n - t), 16'h1);
        chk(16'(rxr_n - r), 16'h1);
        chk(ser_a, par_a);
        chk(16'(ra_n > n), 16'h1);
        chk(rxp_a, dec_a);
        mdio(1'b1, PA, `RSD_REG_CH_STATUS, 16'h0, rd);
        chk(rd[10], 1'b1);
        t = txr_n;
        collide <= 2'h1;
        @(posedge hclk);
        collide <= 2'h0;
        repeat (3) @(posedge hclk);
        chk(16'(txr_n - t), 16'h1);
        lock <= 2'h0;
    endtask

    // held handover on channel b released by the recenter write
    task automatic t_hold();
        int n;
        wr(PB, `RSD_REG_ARS_CTRL, 16'hBEA5);
        n = rb_n;
        repeat (40) @(posedge hclk);
        chk(16'(rb_n > n), 16'h1);
        lock <= 2'h2;
        repeat (20) @(posedge hclk);
        chk(ser_b, 10'h2A5);
        wr(PB, `RSD_REG_CH_CTRL, 16'h0004);
        chk(ser_b, par_b);
        chk(rxp_b, dec_b);
    endtask

    // parallel data without override, and inert bits with sensing off
    task automatic t_pass();
        int n;
        wr(PA, `RSD_REG_ARS_CTRL, 16'h3AA5);
        par_a <= 10'h2C3;
        repeat (4) @(posedge hclk);
        chk(ser_a, 10'h2C3);
        wr(PA, `RSD_REG_ARS_CTRL, 16'h06A5);
        n = ra_n;
        repeat (40) @(posedge hclk);
        chk(ser_a, par_a);
        chk(16'(ra_n > n), 16'h1);
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_ind();
        t_ovr();
        t_hold();
        t_pass();
        finish_test();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (60000) @(posedge hclk);
        bad_count++;
        finish_test();
    end
endmodule
